/* File: design/afe_cfg_map.svh */
// Register map, field positions, reset values and timing counts of the configuration bank.
`ifndef AFE_CFG_MAP_SVH
`define AFE_CFG_MAP_SVH

// Register offsets on the serial register port.
`define REG_SLEEP_CONTROL      8'h04
`define REG_FEATURE_SET_CONFIG 8'h07
`define REG_WRITE_ENABLE_FLAGS 8'h08

// Sleep control fields.
`define BIT_FORCE_SLEEP        7

// Feature set fields.
`define BIT_AUTO_SCAN_OFF      7
`define BIT_REGULATOR_DISABLE  6
`define BIT_TEMP_SUPPLY_FORCE  5
`define BIT_SOFT_POR           2
`define BIT_WAKE_PIN_DISABLE   1
`define BIT_WAKE_POLARITY      0
`define FEATURE_STORE_MASK     8'hE3

// Write enable and flag fields.
`define BIT_FEATURE_WRITE_EN   7
`define BIT_USER_FLAG_HI       4
`define BIT_USER_FLAG_LO       3

// Reset values.
`define RST_FEATURE_SET        8'h00
`define RST_FEATURE_WRITE_EN   1'b0
`define RST_WAKE_POLARITY      1'b0

// Analog output select code that routes the external temperature.
`define AO_SEL_EXT_TEMP        4'h8

// Timing.
`define MCLK_KHZ               200000
`define SCAN_PERIOD_MS         640
`define SCAN_ON_MS             5
`define OT_ARM_MS              1
`define SCAN_PERIOD_CYC        (`SCAN_PERIOD_MS * `MCLK_KHZ)
`define SCAN_ON_CYC            (`SCAN_ON_MS * `MCLK_KHZ)
`define OT_ARM_CYC             (`OT_ARM_MS * `MCLK_KHZ)

`endif

/* File: design/afe_cfg_pkg.sv */
// Types shared by the configuration bank.
package afe_cfg_pkg;

    // Power state of the front end.
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_AWAKE,
        PWR_ASLEEP
    } pwr_state_t;

endpackage

/* File: design/afe_sync2.sv */
// Two flip-flop synchroniser for a bus of independent levels.
`timescale 1ns/1ps
module afe_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
        if (rst) begin
            meta_nxt = '0;
            q_nxt    = '0;
        end
    end

    always_ff @(posedge clk) begin
        meta_r <= meta_nxt;
        q      <= q_nxt;
    end

endmodule

/* File: design/battery_afe_config_regs.sv */
// Configuration bank, power state, wake logic and temperature scan of the front end.
`timescale 1ns/1ps
`include "afe_cfg_map.svh"
module battery_afe_config_regs #(
    parameter int unsigned SCAN_PERIOD_CYC = `SCAN_PERIOD_CYC,
    parameter int unsigned SCAN_ON_CYC     = `SCAN_ON_CYC,
    parameter int unsigned OT_ARM_CYC      = `OT_ARM_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       lnk_clk,
    input  wire logic       lnk_req,
    input  wire logic       lnk_wr,
    input  wire logic [7:0] lnk_addr,
    input  wire logic [7:0] lnk_wdata,
    output logic            lnk_busy,
    output logic            lnk_done,
    output logic      [7:0] lnk_rdata,
    input  wire logic       supplies_ok,
    input  wire logic       wake_pin,
    input  wire logic [3:0] analog_out_select,
    output logic            regulated_supply_out,
    output logic            regulator_ctrl_en,
    output logic            temp_sensor_supply,
    output logic            ext_ot_arm,
    output logic            sleeping
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: capture a request, toggle it across, wait for the returned toggle.

    logic       lnk_rst;
    logic       ack_tgl_l;
    logic       req_tgl_r;
    logic       req_tgl_nxt;
    logic       lnk_wr_r;
    logic       lnk_wr_nxt;
    logic [7:0] lnk_addr_r;
    logic [7:0] lnk_addr_nxt;
    logic [7:0] lnk_wdata_r;
    logic [7:0] lnk_wdata_nxt;
    logic       ack_seen_r;
    logic       ack_seen_nxt;
    logic       lnk_done_nxt;
    logic [7:0] lnk_rdata_nxt;
    logic [7:0] rdata_r;
    logic       ack_tgl_r;

    afe_sync2 #(.W(1)) u_lnk_rst_sync (
        .clk (lnk_clk),
        .rst (1'b0),
        .d   (rst),
        .q   (lnk_rst)
    );

    afe_sync2 #(.W(1)) u_ack_sync (
        .clk (lnk_clk),
        .rst (lnk_rst),
        .d   (ack_tgl_r),
        .q   (ack_tgl_l)
    );

    // Busy while a toggle is outstanding; a request then is ignored.
    assign lnk_busy = (req_tgl_r != ack_seen_r);

    // Hold registers stay stable while busy, so the system side may read them directly.
    always_comb begin
        req_tgl_nxt   = req_tgl_r;
        lnk_wr_nxt    = lnk_wr_r;
        lnk_addr_nxt  = lnk_addr_r;
        lnk_wdata_nxt = lnk_wdata_r;
        ack_seen_nxt  = ack_tgl_l;
        lnk_done_nxt  = (ack_tgl_l != ack_seen_r);
        lnk_rdata_nxt = lnk_rdata;
        if (ack_tgl_l != ack_seen_r) begin
            lnk_rdata_nxt = rdata_r;
        end
        if (lnk_req && !lnk_busy) begin
            req_tgl_nxt   = ~req_tgl_r;
            lnk_wr_nxt    = lnk_wr;
            lnk_addr_nxt  = lnk_addr;
            lnk_wdata_nxt = lnk_wdata;
        end
        if (lnk_rst) begin
            req_tgl_nxt   = 1'b0;
            lnk_wr_nxt    = 1'b0;
            lnk_addr_nxt  = 8'h00;
            lnk_wdata_nxt = 8'h00;
            ack_seen_nxt  = 1'b0;
            lnk_done_nxt  = 1'b0;
            lnk_rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge lnk_clk) begin
        req_tgl_r   <= req_tgl_nxt;
        lnk_wr_r    <= lnk_wr_nxt;
        lnk_addr_r  <= lnk_addr_nxt;
        lnk_wdata_r <= lnk_wdata_nxt;
        ack_seen_r  <= ack_seen_nxt;
        lnk_done    <= lnk_done_nxt;
        lnk_rdata   <= lnk_rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: pin synchronisers and request detection.

    logic       req_tgl_s;
    logic       supplies_ok_s;
    logic       wake_pin_s;
    logic       req_seen_r;
    logic       wake_prev_r;
    logic       acc_go;
    logic       wr_go;

    afe_sync2 #(.W(3)) u_sys_sync (
        .clk (mclk),
        .rst (rst),
        .d   ({req_tgl_r, supplies_ok, wake_pin}),
        .q   ({req_tgl_s, supplies_ok_s, wake_pin_s})
    );

    assign acc_go = (req_tgl_s != req_seen_r);
    assign wr_go  = acc_go && lnk_wr_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bank and power state.

    afe_cfg_pkg::pwr_state_t state_r;
    afe_cfg_pkg::pwr_state_t state_nxt;
    logic       force_sleep_r;
    logic       force_sleep_nxt;
    logic [7:0] feature_r;
    logic [7:0] feature_nxt;
    logic       feat_wr_en_r;
    logic       feat_wr_en_nxt;
    logic [1:0] user_flags_r;
    logic [1:0] user_flags_nxt;
    logic       req_seen_nxt;
    logic       wake_prev_nxt;
    logic       ack_tgl_nxt;
    logic [7:0] rdata_nxt;
    logic       soft_por;
    logic       wake_edge;
    logic       wake_pol;

    assign wake_pol = feature_r[`BIT_WAKE_POLARITY];
    // Rising edge with polarity one, falling edge with polarity zero.
    assign wake_edge = wake_pol ? (wake_pin_s && !wake_prev_r)
                                : (!wake_pin_s && wake_prev_r);
    // A permitted write with the reset bit set behaves like power-on reset.
    assign soft_por = wr_go && (lnk_addr_r == `REG_FEATURE_SET_CONFIG)
                      && feat_wr_en_r && lnk_wdata_r[`BIT_SOFT_POR];

    // Register updates, read answers and power transitions.
    always_comb begin
        state_nxt       = state_r;
        force_sleep_nxt = force_sleep_r;
        feature_nxt     = feature_r;
        feat_wr_en_nxt  = feat_wr_en_r;
        user_flags_nxt  = user_flags_r;
        req_seen_nxt    = req_tgl_s;
        wake_prev_nxt   = wake_pin_s;
        ack_tgl_nxt     = ack_tgl_r;
        rdata_nxt       = rdata_r;
        if (acc_go) begin
            ack_tgl_nxt = ~ack_tgl_r;
            // Reserved positions read zero and unmapped offsets read zero.
            unique case (lnk_addr_r)
                `REG_SLEEP_CONTROL:      rdata_nxt = {force_sleep_r, 7'h00};
                `REG_FEATURE_SET_CONFIG: rdata_nxt = feature_r;
                `REG_WRITE_ENABLE_FLAGS: rdata_nxt = {feat_wr_en_r, 2'h0,
                                                      user_flags_r, 3'h0};
                default:                 rdata_nxt = 8'h00;
            endcase
        end
        if (wr_go) begin
            unique case (lnk_addr_r)
                `REG_SLEEP_CONTROL: begin
                    if (lnk_wdata_r[`BIT_FORCE_SLEEP] && state_r == afe_cfg_pkg::PWR_AWAKE) begin
                        force_sleep_nxt = 1'b1;
                        state_nxt       = afe_cfg_pkg::PWR_ASLEEP;
                    end
                end
                `REG_FEATURE_SET_CONFIG: begin
                    if (feat_wr_en_r) begin
                        feature_nxt = lnk_wdata_r & `FEATURE_STORE_MASK;
                    end
                end
                `REG_WRITE_ENABLE_FLAGS: begin
                    feat_wr_en_nxt = lnk_wdata_r[`BIT_FEATURE_WRITE_EN];
                    user_flags_nxt = {lnk_wdata_r[`BIT_USER_FLAG_HI],
                                      lnk_wdata_r[`BIT_USER_FLAG_LO]};
                end
                default: begin
                end
            endcase
        end
        // Power transitions; flags and settings survive sleep because nothing clears them.
        unique case (state_r)
            afe_cfg_pkg::PWR_OFF: begin
                if (supplies_ok_s) begin
                    state_nxt = afe_cfg_pkg::PWR_AWAKE;
                end
            end
            afe_cfg_pkg::PWR_AWAKE: begin
            end
            afe_cfg_pkg::PWR_ASLEEP: begin
                if (wake_edge && !feature_r[`BIT_WAKE_PIN_DISABLE]) begin
                    state_nxt       = afe_cfg_pkg::PWR_AWAKE;
                    force_sleep_nxt = 1'b0;
                end
            end
        endcase
        if (!supplies_ok_s) begin
            state_nxt       = afe_cfg_pkg::PWR_OFF;
            force_sleep_nxt = 1'b0;
        end
        // Hard and soft reset clear the whole bank and restart power-up.
        if (rst || soft_por) begin
            state_nxt       = afe_cfg_pkg::PWR_OFF;
            force_sleep_nxt = 1'b0;
            feature_nxt     = `RST_FEATURE_SET;
            feat_wr_en_nxt  = `RST_FEATURE_WRITE_EN;
            user_flags_nxt  = 2'h0;
        end
        if (rst) begin
            req_seen_nxt  = 1'b0;
            wake_prev_nxt = 1'b0;
            ack_tgl_nxt   = 1'b0;
            rdata_nxt     = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        state_r       <= state_nxt;
        force_sleep_r <= force_sleep_nxt;
        feature_r     <= feature_nxt;
        feat_wr_en_r  <= feat_wr_en_nxt;
        user_flags_r  <= user_flags_nxt;
        req_seen_r    <= req_seen_nxt;
        wake_prev_r   <= wake_prev_nxt;
        ack_tgl_r     <= ack_tgl_nxt;
        rdata_r       <= rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Temperature supply scan and over-temperature arming.

    logic [26:0] scan_cnt_r;
    logic [26:0] scan_cnt_nxt;
    logic [17:0] arm_cnt_r;
    logic [17:0] arm_cnt_nxt;
    logic        awake;
    logic        auto_win;
    logic        temp_on;
    logic        reg_on_nxt;
    logic        reg_ctl_nxt;
    logic        temp_nxt;
    logic        arm_nxt;
    logic        sleeping_nxt;

    assign awake = (state_r == afe_cfg_pkg::PWR_AWAKE);
    // The scan only runs while the regulated rail is up; asleep it has no supply.
    assign auto_win = !feature_r[`BIT_AUTO_SCAN_OFF]
                      && (scan_cnt_r < 27'(SCAN_ON_CYC));
    // Select field is sampled as given; sleep does not alter it.
    assign temp_on = awake && (feature_r[`BIT_TEMP_SUPPLY_FORCE]
                               || analog_out_select == `AO_SEL_EXT_TEMP
                               || auto_win);

    // Scan period counter, the arming delay and the registered pin outputs.
    always_comb begin
        scan_cnt_nxt = scan_cnt_r + 27'h0000001;
        if (!awake || scan_cnt_r == 27'(SCAN_PERIOD_CYC - 1)) begin
            scan_cnt_nxt = 27'h0000000;
        end
        arm_cnt_nxt = 18'h00000;
        if (temp_on) begin
            arm_cnt_nxt = arm_cnt_r;
            if (arm_cnt_r != 18'(OT_ARM_CYC)) begin
                arm_cnt_nxt = arm_cnt_r + 18'h00001;
            end
        end
        reg_on_nxt   = awake;
        reg_ctl_nxt  = awake && !feature_r[`BIT_REGULATOR_DISABLE];
        temp_nxt     = temp_on;
        arm_nxt      = temp_on && (arm_cnt_r == 18'(OT_ARM_CYC));
        sleeping_nxt = (state_r == afe_cfg_pkg::PWR_ASLEEP);
        if (rst) begin
            scan_cnt_nxt = 27'h0000000;
            arm_cnt_nxt  = 18'h00000;
            reg_on_nxt   = 1'b0;
            reg_ctl_nxt  = 1'b0;
            temp_nxt     = 1'b0;
            arm_nxt      = 1'b0;
            sleeping_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        scan_cnt_r           <= scan_cnt_nxt;
        arm_cnt_r            <= arm_cnt_nxt;
        regulated_supply_out <= reg_on_nxt;
        regulator_ctrl_en    <= reg_ctl_nxt;
        temp_sensor_supply   <= temp_nxt;
        ext_ot_arm           <= arm_nxt;
        sleeping             <= sleeping_nxt;
    end

endmodule

/* File: tb/battery_afe_config_regs_asserts.sv */
// Concurrent checks on the ports of the configuration bank.
`timescale 1ns/1ps
module afe_cfg_checker #(
    parameter int unsigned SCAN_PERIOD_CYC = 64,
    parameter int unsigned SCAN_ON_CYC     = 5,
    parameter int unsigned OT_ARM_CYC      = 3
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       lnk_clk,
    input wire logic       lnk_busy,
    input wire logic       lnk_done,
    input wire logic       supplies_ok,
    input wire logic [3:0] analog_out_select,
    input wire logic       regulated_supply_out,
    input wire logic       regulator_ctrl_en,
    input wire logic       temp_sensor_supply,
    input wire logic       ext_ot_arm,
    input wire logic       sleeping
);
    ////////////////////////////////////////////////////////////////////////////////
    // Power state against the rail and the sensor supply.
    a_sleep_rail_off: assert property (@(posedge mclk) disable iff (rst)
        sleeping |-> !regulated_supply_out) else $error("rail on while asleep");
    a_ctrl_needs_rail: assert property (@(posedge mclk) disable iff (rst)
        regulator_ctrl_en |-> regulated_supply_out) else $error("regulator on without rail");
    a_supply_low_off: assert property (@(posedge mclk) disable iff (rst)
        !supplies_ok [*6] |-> !regulated_supply_out) else $error("rail on with supplies low");
    a_asleep_no_temp: assert property (@(posedge mclk) disable iff (rst)
        sleeping [*2] |-> !temp_sensor_supply) else $error("sensor supply on asleep");
    // A short window is the usual slip, so every fall with the rail up needs the supply on five cycles before it.
    a_scan_window: assert property (@(posedge mclk) disable iff (rst)
        $fell(temp_sensor_supply) && regulated_supply_out |-> $past(temp_sensor_supply, 5))
        else $error("sensor supply window too short");
    a_select_temp: assert property (@(posedge mclk) disable iff (rst)
        (regulated_supply_out && analog_out_select == 4'h8) [*3] |-> temp_sensor_supply)
        else $error("sensor supply off with temperature selected");
    a_arm_delay: assert property (@(posedge mclk) disable iff (rst)
        ext_ot_arm |-> $past(temp_sensor_supply, 2)) else $error("armed too early");
    a_link_answer: assert property (@(posedge lnk_clk) disable iff (rst)
        $rose(lnk_busy) |-> ##[3:8] lnk_done) else $error("access not answered");
    c_sleep: cover property (@(posedge mclk) disable iff (rst) $rose(sleeping));
    c_arm: cover property (@(posedge mclk) disable iff (rst) $rose(ext_ot_arm));
    c_done: cover property (@(posedge lnk_clk) disable iff (rst) lnk_done);
endmodule

bind battery_afe_config_regs afe_cfg_checker #(
    .SCAN_PERIOD_CYC(SCAN_PERIOD_CYC),
    .SCAN_ON_CYC    (SCAN_ON_CYC),
    .OT_ARM_CYC     (OT_ARM_CYC)
) u_chk (
    .mclk                (mclk),
    .rst                 (rst),
    .lnk_clk             (lnk_clk),
    .lnk_busy            (lnk_busy),
    .lnk_done            (lnk_done),
    .supplies_ok         (supplies_ok),
    .analog_out_select   (analog_out_select),
    .regulated_supply_out(regulated_supply_out),
    .regulator_ctrl_en   (regulator_ctrl_en),
    .temp_sensor_supply  (temp_sensor_supply),
    .ext_ot_arm          (ext_ot_arm),
    .sleeping            (sleeping)
);

/* File: tb/afe_host_model.sv */
// Host model issuing single-byte accesses on the link port.
`timescale 1ns/1ps
module afe_host_model (
    input  wire logic       lnk_clk,
    input  wire logic       lnk_done,
    input  wire logic [7:0] lnk_rdata,
    output logic            lnk_req,
    output logic            lnk_wr,
    output logic      [7:0] lnk_addr,
    output logic      [7:0] lnk_wdata,
    output logic            timed_out
);
    // Idle values at time zero.
    initial begin
        lnk_req   = 1'b0;
        lnk_wr    = 1'b0;
        lnk_addr  = 8'h00;
        lnk_wdata = 8'h00;
        timed_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One access at a time; qualifiers stay put until done, then show their inverse
    // so that a design sampling late cannot see a stale but correct value.
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          input int gap, output logic [7:0] rdata);
        int n;
        n = 0;
        repeat (gap) @(posedge lnk_clk);
        @(posedge lnk_clk);
        lnk_req   <= 1'b1;
        lnk_wr    <= wr;
        lnk_addr  <= addr;
        lnk_wdata <= wdata;
        @(posedge lnk_clk);
        lnk_req <= 1'b0;
        while (lnk_done !== 1'b1 && n < 20) begin
            @(posedge lnk_clk);
            n++;
        end
        if (n == 20) timed_out <= 1'b1;
        rdata = lnk_rdata;
        lnk_wr    <= ~wr;
        lnk_addr  <= ~addr;
        lnk_wdata <= ~wdata;
    endtask
endmodule

/* File: tb/battery_afe_config_regs_tb.sv */
// Self-checking bench for the configuration bank.
`timescale 1ns/1ps
module battery_afe_config_regs_tb;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } row_t;
    logic       mclk, lnk_clk, rst, supplies_ok, wake_pin, timed_out;
    logic [3:0] analog_out_select;
    logic       lnk_req, lnk_wr, lnk_busy, lnk_done;
    logic [7:0] lnk_addr, lnk_wdata, lnk_rdata, rd;
    logic       regulated_supply_out, regulator_ctrl_en, temp_sensor_supply;
    logic       ext_ot_arm, sleeping;
    int         num_errors = 0;
    int         n_compared = 0;
    int         cycles = 0;
    int         hi;
    row_t       rows [14];

    battery_afe_config_regs #(.SCAN_PERIOD_CYC(64), .SCAN_ON_CYC(5), .OT_ARM_CYC(3)) u_dut (
        .mclk(mclk), .rst(rst), .lnk_clk(lnk_clk), .lnk_req(lnk_req), .lnk_wr(lnk_wr),
        .lnk_addr(lnk_addr), .lnk_wdata(lnk_wdata), .lnk_busy(lnk_busy),
        .lnk_done(lnk_done), .lnk_rdata(lnk_rdata), .supplies_ok(supplies_ok),
        .wake_pin(wake_pin), .analog_out_select(analog_out_select),
        .regulated_supply_out(regulated_supply_out), .regulator_ctrl_en(regulator_ctrl_en),
        .temp_sensor_supply(temp_sensor_supply), .ext_ot_arm(ext_ot_arm),
        .sleeping(sleeping));
    afe_host_model u_host (.lnk_clk(lnk_clk), .lnk_done(lnk_done), .lnk_rdata(lnk_rdata),
        .lnk_req(lnk_req), .lnk_wr(lnk_wr), .lnk_addr(lnk_addr), .lnk_wdata(lnk_wdata),
        .timed_out(timed_out));

    ////////////////////////////////////////////////////////////////////////////////
    // Two unrelated clocks; the link one starts off phase.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        lnk_clk = 1'b0;
        #7.3;
        forever #32 lnk_clk = ~lnk_clk;
    end

    task automatic stop_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp, input string s);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string s);
        check_reg({7'h00, got}, {7'h00, exp}, s);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.access(1'b1, a, d, 0, rd);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string s);
        u_host.access(1'b0, a, 8'h00, 1, rd);
        check_reg(rd, exp, s);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic drive(input logic ok, input logic w, input logic [3:0] sel);
        @(posedge mclk);
        supplies_ok       <= ok;
        wake_pin          <= w;
        analog_out_select <= sel;
    endtask
    task automatic count_hi(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge mclk);
            hi += (temp_sensor_supply === 1'b1);
        end
    endtask

    // A hung access or a run past its expected length ends the test.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000 || timed_out === 1'b1) begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register table first, then power, wake, scan and reset cases by hand.
    initial begin
        rst = 1'b1;
        supplies_ok = 1'b1;
        wake_pin = 1'b1;
        analog_out_select = 4'h0;
        rows = '{'{1'b0, 8'h07, 8'h00}, '{1'b0, 8'h08, 8'h00}, '{1'b1, 8'h07, 8'hFF},
                 '{1'b0, 8'h07, 8'h00}, '{1'b1, 8'h08, 8'hFF}, '{1'b0, 8'h08, 8'h98},
                 '{1'b1, 8'h07, 8'hFB}, '{1'b0, 8'h07, 8'hE3}, '{1'b0, 8'h04, 8'h00},
                 '{1'b0, 8'h05, 8'h00}, '{1'b1, 8'h08, 8'h18}, '{1'b1, 8'h07, 8'h00},
                 '{1'b0, 8'h07, 8'hE3}, '{1'b0, 8'h08, 8'h18}};
        repeat (3) @(posedge lnk_clk);
        @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge lnk_clk);
        check_bit(regulated_supply_out, 1'b1, "rail after power-up");
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].data);
            else rdchk(rows[i].addr, rows[i].data, "row read");
        end
        tick(4);
        check_bit(regulator_ctrl_en, 1'b0, "regulator control");
        check_bit(temp_sensor_supply, 1'b1, "forced sensor supply");
        wr(8'h08, 8'h80);
        wr(8'h07, 8'h00);
        tick(64);
        check_bit(regulator_ctrl_en, 1'b1, "regulator control on");
        count_hi(128);
        check_reg(hi[7:0], 8'h0A, "scan on cycles");
        // Park the supply on the force bit first, so turning the scan off cuts no window.
        wr(8'h07, 8'hA0);
        wr(8'h07, 8'h80);
        tick(64);
        count_hi(128);
        check_reg(hi[7:0], 8'h00, "scan suppressed");
        drive(1'b1, 1'b1, 4'h8);
        tick(8);
        check_bit(ext_ot_arm, 1'b1, "arm on selected temperature");
        drive(1'b1, 1'b0, 4'h3);
        wr(8'h04, 8'h80);
        tick(4);
        check_bit(regulated_supply_out, 1'b0, "rail asleep");
        rdchk(8'h04, 8'h80, "sleep bit");
        drive(1'b1, 1'b1, 4'h3);
        tick(8);
        check_bit(sleeping, 1'b1, "rising edge with falling polarity");
        drive(1'b1, 1'b0, 4'h3);
        tick(8);
        check_bit(sleeping, 1'b0, "falling edge wakes");
        rdchk(8'h04, 8'h00, "sleep bit after wake");
        wr(8'h07, 8'h82);
        wr(8'h04, 8'h80);
        drive(1'b1, 1'b1, 4'h3);
        tick(4);
        drive(1'b1, 1'b0, 4'h3);
        tick(8);
        check_bit(sleeping, 1'b1, "wake pin disabled");
        wr(8'h07, 8'h81);
        drive(1'b1, 1'b1, 4'h3);
        tick(8);
        check_bit(sleeping, 1'b0, "rising edge wakes");
        wr(8'h08, 8'h98);
        wr(8'h07, 8'h84);
        tick(8);
        rdchk(8'h08, 8'h00, "flags after soft reset");
        rdchk(8'h07, 8'h00, "feature after soft reset");
        wr(8'h08, 8'h18);
        drive(1'b0, 1'b0, 4'h3);
        tick(8);
        check_bit(regulated_supply_out, 1'b0, "rail with supplies low");
        drive(1'b1, 1'b0, 4'h3);
        tick(8);
        check_bit(regulated_supply_out, 1'b1, "rail back");
        rdchk(8'h08, 8'h18, "flags kept");
        stop_test;
    end
endmodule
